/* File: fis_cfg.svh */
// constants for the fragment input setup block
`ifndef FIS_CFG_SVH
`define FIS_CFG_SVH
`define FIS_XY_W       24
`define FIS_HALF_PIX   25'h0000080
`define FIS_ONE_F      32'h3F80_0000
`define FIS_MASK_BITS  32
`define FIS_POS_CTR    8'h80
`define FIS_REG_CTRL   8'h00
`define FIS_REG_SAMP   8'h04
`define FIS_REG_HGT    8'h08
`define FIS_REG_SMASK  8'h0C
`define FIS_REG_PRIM   8'h10
`define FIS_REG_INV    8'h14
`define FIS_CTRL_RST   7'h00
`define FIS_SAMP_RST   3'h0
`define FIS_HGT_RST    16'h0000
`define FIS_SMASK_RST  32'hFFFF_FFFF
`define FIS_NONE       6'h20
`define FIS_SW_ZERO    3'h4
`define FIS_SW_ONE     3'h5
`endif

/* File: fis_pkg.sv */
// types shared by the fragment input setup modules
`include "fis_cfg.svh"
package fis_pkg;
   typedef logic [3:0][31:0] fis_vec4_t;
   typedef struct packed {
      logic geo;
      logic psmp;
      logic msen;
      logic cw;
      logic orul;
      logic pci;
      logic shd;
   } fis_ctrl_t;
   typedef struct packed {
      logic [`FIS_XY_W-1:0] x;
      logic [`FIS_XY_W-1:0] y;
      logic [31:0]          z;
      logic [31:0]          wc;
      logic                 col_fix;
      fis_vec4_t            pcol;
      fis_vec4_t            scol;
      logic                 poly;
      logic signed [31:0]   area;
      logic [31:0]          cov;
      logic [31:0]          kill;
      logic [31:0]          gs_id;
   } fis_frag_in_t;
   typedef struct packed {
      logic [`FIS_XY_W:0] px;
      logic [`FIS_XY_W:0] py;
      logic [31:0]        z;
      logic [31:0]        w;
      fis_vec4_t          pcol;
      fis_vec4_t          scol;
      logic               front;
      logic [31:0]        prim_id;
      logic [31:0]        mask;
      logic [4:0]         sid;
      logic [5:0]         scnt;
      logic [7:0]         spx;
      logic [7:0]         spy;
   } fis_frag_out_t;
   typedef struct packed {
      logic batch;
      logic prim_end;
      logic last;
      logic restart;
   } fis_prim_ev_t;
   typedef struct packed {
      logic            depth;
      logic            dstencil;
      logic            shadow;
      logic            complete;
      logic [31:0]     rt;
      fis_vec4_t       texel;
      logic [3:0][2:0] swz;
   } fis_tex_req_t;
   typedef struct packed {
      fis_vec4_t v;
      logic      scalar;
   } fis_tex_rsp_t;
   typedef enum logic [1:0] {FIS_IDLE, FIS_DIV, FIS_EMIT, FIS_FF} fis_st_t;
endpackage : fis_pkg

/* File: fis_colour.sv */
// colour conversion of fixed-point components to float
`timescale 1ns/1ps
`include "fis_cfg.svh"
module fis_colour
   import fis_pkg::*;
(
   input  wire logic      is_fix,
   input  wire fis_vec4_t pin,
   input  wire fis_vec4_t sin,
   output fis_vec4_t      pout,
   output fis_vec4_t      sout
);
   // unorm8 to float; ends forced so 0 and 1 stay exact
   function automatic logic [31:0] fis_u2f(input logic [7:0] c);
      logic [31:0] f;
      logic [2:0]  lz;
      f = {c, c, c, c};
      lz = 3'h0;
      // leading zeros of the replicated word equal those of c
      for (int i = 0; i < 8; i++)
         if (c[i])
            lz = 3'(7 - i);
      f = f << lz;
      fis_u2f = {1'b0, 8'(8'h7E - {5'h00, lz}), f[30:8]};
      if (c == 8'h00)
         fis_u2f = 32'h0000_0000;
      if (c == 8'hFF)
         fis_u2f = `FIS_ONE_F;
   endfunction : fis_u2f

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pout[k] = is_fix ? fis_u2f(pin[k][7:0]) : pin[k];
         sout[k] = is_fix ? fis_u2f(sin[k][7:0]) : sin[k];
      end
   end
endmodule : fis_colour

/* File: fis_recip.sv */
// sequential reciprocal of an unsigned 16.16 value
`timescale 1ns/1ps
module fis_recip #(
   parameter int W = 32
)(
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic         start,
   input  wire logic [W-1:0] divisor,
   output logic              done,
   output logic [W-1:0]      quot
);
   logic [W:0]   rem_q;
   logic [W:0]   dbl;
   logic [W-1:0] div_q;
   logic [W-1:0] q_q;
   logic [5:0]   it_q;
   logic         run_q;
   logic         sat_q;

   if (W < 2 || W > 32) begin : g_bad
      $error("fis_recip width must be 2 to 32");
   end

   assign dbl = {rem_q[W-1:0], 1'b0};
   // zero or one would overflow 16.16, so saturate
   assign quot = sat_q ? '1 : q_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rem_q <= '0;
         div_q <= '0;
         q_q <= '0;
         it_q <= 6'h00;
         run_q <= 1'b0;
         sat_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            rem_q <= (W+1)'(1);
            div_q <= divisor;
            q_q <= '0;
            it_q <= 6'h00;
            run_q <= 1'b1;
            sat_q <= divisor <= W'(1);
         end else if (run_q) begin
            if (dbl >= {1'b0, div_q}) begin
               rem_q <= dbl - {1'b0, div_q};
               q_q <= {q_q[W-2:0], 1'b1};
            end else begin
               rem_q <= dbl;
               q_q <= {q_q[W-2:0], 1'b0};
            end
            it_q <= it_q + 6'h01;
            if (it_q == 6'(W - 1)) begin
               run_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule : fis_recip

/* File: fis_top.sv */
// fragment input setup: rasterized fragment to shader built-ins
`timescale 1ns/1ps
// Function
// - with shader on, fragments skip fixed texturing, colour sum, fog
// - depth lookups give (Rt,0,0,1), swizzled, first component only
// - incomplete texture returns (0,0,0,1), or 0 for shadow sampler
// - stencil part of depth-stencil textures is ignored in lookups
// - integer pixel centre subtracts one half from x and y
// - upper-left origin gives y as height minus y before centring
// - z passes exactly; w is reciprocal of clip w
// - defaults are half-integer centre and lower-left origin
// - fixed-point colours convert to float keeping 0 and 1 exact
// - polygons face front on positive signed area, negative with cw set; others always front
// - primitive counter zeroed at batch start; geometry stage gives id
// - count once per polygon drawn as points/lines, once per quad
// - primitive restart leaves the counter alone
// - covered mask bit n of word w is sample 32w+n
// - single-sample or no multisampling: only bit zero, pixel coverage
// - with multisampling on, samples killed by coverage value or sample mask stay clear
// - per-sample shading sets only the current sample bit, once each
// - sample number below count; zero without multisampling
// - sample count is framebuffer count regardless of enable
// - sample position in [0,1]; 0.5,0.5 without multisampling
// - reading sample number or position runs shader per sample
`include "fis_cfg.svh"
module fis_top
   import fis_pkg::*;
#(
   parameter int MAX_SAMPLES = 32
)(
   input  wire logic          sys_clk,
   input  wire logic          reset,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          frag_valid,
   output logic               frag_ready,
   input  wire fis_frag_in_t  frag_in,
   output logic               sh_valid,
   input  wire logic          sh_ready,
   output fis_frag_out_t      sh_out,
   output logic               ff_valid,
   input  wire logic          ff_ready,
   output fis_frag_in_t       ff_out,
   input  wire fis_prim_ev_t  prim_ev,
   input  wire logic          tex_req_valid,
   input  wire fis_tex_req_t  tex_req,
   output logic               tex_rsp_valid,
   output fis_tex_rsp_t       tex_rsp
);
   localparam logic [2:0] LG_MAX = 3'($clog2(MAX_SAMPLES));

   if (MAX_SAMPLES < 1 || MAX_SAMPLES > `FIS_MASK_BITS ||
       (MAX_SAMPLES & (MAX_SAMPLES - 1)) != 0) begin : g_bad
      $error("MAX_SAMPLES must be a power of two up to 32");
   end

   fis_ctrl_t     ctrl_q;
   logic [2:0]    slog2_q;
   logic [15:0]   hgt_q;
   logic [31:0]   smask_q;
   logic [31:0]   prim_cnt_q;
   logic [31:0]   inv_cnt_q;
   logic [31:0]   rd_d;
   logic          err_d;
   logic          apb_acc;
   logic          apb_wr;
   fis_st_t       st_q;
   logic [31:0]   eff_q;
   logic [2:0]    lg_q;
   logic          ps_q;
   logic          accept;
   logic          rc_done;
   logic [31:0]   rc_quot;
   fis_vec4_t     pcol_f;
   fis_vec4_t     scol_f;
   logic [2:0]    lg;
   logic          multi;
   logic          ps;
   logic [31:0]   lim;
   logic [31:0]   eff;
   logic [5:0]    first;
   logic [5:0]    nxt;
   logic [24:0]   yp;
   fis_frag_out_t cap;
   fis_vec4_t     cb;
   fis_tex_rsp_t  rsp_d;
   logic          isdepth;

   function automatic logic [5:0] fis_first(input logic [31:0] m);
      fis_first = `FIS_NONE;
      for (int i = 31; i >= 0; i--)
         if (m[i])
            fis_first = 6'(i);
   endfunction : fis_first

   // diagonal pattern (2i+1)/2N, mirrored in y
   function automatic logic [7:0] fis_spos(input logic [4:0] idx,
                                           input logic [2:0] l,
                                           input logic       flip);
      logic [4:0]  j;
      logic [13:0] t;
      j = flip ? 5'((6'h01 << l) - 6'h01) - idx : idx;
      t = {1'b0, j, 1'b1, 7'h00} >> l;
      fis_spos = t[7:0];
   endfunction : fis_spos

   function automatic logic [31:0] fis_swz(input fis_vec4_t c,
                                           input logic [2:0] s);
      case (s)
         `FIS_SW_ZERO: fis_swz = 32'h0000_0000;
         `FIS_SW_ONE:  fis_swz = `FIS_ONE_F;
         default:      fis_swz = c[s[1:0]];
      endcase
   endfunction : fis_swz

   // apb slave: one wait state on every access
   assign apb_acc = psel & penable;
   assign apb_wr = apb_acc & pready & pwrite & ~pslverr;

   always_comb begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr)
         `FIS_REG_CTRL:  rd_d = {25'h0, ctrl_q};
         `FIS_REG_SAMP:  rd_d = {29'h0, slog2_q};
         `FIS_REG_HGT:   rd_d = {16'h0, hgt_q};
         `FIS_REG_SMASK: rd_d = smask_q;
         `FIS_REG_PRIM:  rd_d = prim_cnt_q;
         `FIS_REG_INV:   rd_d = inv_cnt_q;
         default:        err_d = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_acc & ~pready;
         if (apb_acc & ~pready) begin
            pslverr <= err_d;
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_q <= `FIS_CTRL_RST;
         slog2_q <= `FIS_SAMP_RST;
         hgt_q <= `FIS_HGT_RST;
         smask_q <= `FIS_SMASK_RST;
      end else if (apb_wr) begin
         case (paddr)
            `FIS_REG_CTRL:  ctrl_q <= pwdata[6:0];
            `FIS_REG_SAMP:  slog2_q <= pwdata[2:0];
            `FIS_REG_HGT:   hgt_q <= pwdata[15:0];
            `FIS_REG_SMASK: smask_q <= pwdata;
            default:        ;
         endcase
      end
   end

   // primitive counter; batch start beats a same-cycle primitive end
   always_ff @(posedge sys_clk) begin
      if (reset)
         prim_cnt_q <= 32'h0000_0000;
      else if (prim_ev.batch)
         prim_cnt_q <= 32'h0000_0000;
      else if (prim_ev.prim_end & prim_ev.last)
         prim_cnt_q <= prim_cnt_q + 32'h0000_0001;
   end

   fis_colour u_colour (
      .is_fix (frag_in.col_fix),
      .pin    (frag_in.pcol),
      .sin    (frag_in.scol),
      .pout   (pcol_f),
      .sout   (scol_f)
   );

   fis_recip #(.W(32)) u_recip (
      .sys_clk (sys_clk),
      .reset   (reset),
      .start   (accept & ctrl_q.shd),
      .divisor (frag_in.wc),
      .done    (rc_done),
      .quot    (rc_quot)
   );

   assign accept = frag_valid & frag_ready;

   // shader inputs for an accepted fragment
   always_comb begin
      lg = (slog2_q > LG_MAX) ? LG_MAX : slog2_q;
      multi = ctrl_q.msen & (lg != 3'h0);
      ps = ctrl_q.psmp & multi;
      for (int i = 0; i < 32; i++)
         lim[i] = i < (1 << lg);
      eff = frag_in.cov & smask_q & ~frag_in.kill & lim;
      first = fis_first(eff);
      nxt = fis_first(eff_q & ~((32'h2 << sh_out.sid) - 32'h1));
      yp = ctrl_q.orul ? {1'b0, hgt_q, 8'h00} - {1'b0, frag_in.y}
                       : {1'b0, frag_in.y};
      cap = '0;
      cap.px = ctrl_q.pci ? {1'b0, frag_in.x} - `FIS_HALF_PIX
                          : {1'b0, frag_in.x};
      cap.py = ctrl_q.pci ? yp - `FIS_HALF_PIX : yp;
      cap.z = frag_in.z;
      cap.pcol = pcol_f;
      cap.scol = scol_f;
      cap.front = ~frag_in.poly | (ctrl_q.cw ? frag_in.area < 0
                                             : frag_in.area > 0);
      cap.prim_id = ctrl_q.geo ? frag_in.gs_id : prim_cnt_q;
      cap.scnt = 6'h01 << lg;
      cap.spx = `FIS_POS_CTR;
      cap.spy = `FIS_POS_CTR;
      if (!multi)
         cap.mask = {31'h0, |frag_in.cov};
      else if (!ps)
         cap.mask = eff;
      else if (!first[5]) begin
         cap.mask = 32'h1 << first[4:0];
         cap.sid = first[4:0];
         cap.spx = fis_spos(first[4:0], lg, 1'b0);
         cap.spy = fis_spos(first[4:0], lg, 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= FIS_IDLE;
         frag_ready <= 1'b1;
         sh_valid <= 1'b0;
         sh_out <= '0;
         ff_valid <= 1'b0;
         ff_out <= '0;
         eff_q <= 32'h0000_0000;
         lg_q <= 3'h0;
         ps_q <= 1'b0;
      end else begin
         case (st_q)
            FIS_IDLE: if (accept) begin
               frag_ready <= 1'b0;
               if (ctrl_q.shd) begin
                  sh_out <= cap;
                  eff_q <= eff;
                  lg_q <= lg;
                  ps_q <= ps;
                  st_q <= FIS_DIV;
               end else begin
                  ff_out <= frag_in;
                  ff_valid <= 1'b1;
                  st_q <= FIS_FF;
               end
            end
            FIS_DIV: if (rc_done) begin
               sh_out.w <= rc_quot;
               sh_valid <= 1'b1;
               st_q <= FIS_EMIT;
            end
            FIS_EMIT: if (sh_ready) begin
               if (ps_q && !nxt[5]) begin
                  sh_out.mask <= 32'h1 << nxt[4:0];
                  sh_out.sid <= nxt[4:0];
                  sh_out.spx <= fis_spos(nxt[4:0], lg_q, 1'b0);
                  sh_out.spy <= fis_spos(nxt[4:0], lg_q, 1'b1);
               end else begin
                  sh_valid <= 1'b0;
                  frag_ready <= 1'b1;
                  st_q <= FIS_IDLE;
               end
            end
            FIS_FF: if (ff_ready) begin
               ff_valid <= 1'b0;
               frag_ready <= 1'b1;
               st_q <= FIS_IDLE;
            end
            default: st_q <= FIS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         inv_cnt_q <= 32'h0000_0000;
      else if (sh_valid & sh_ready)
         inv_cnt_q <= inv_cnt_q + 32'h0000_0001;
   end

   // texture return shaping
   always_comb begin
      isdepth = tex_req.depth | tex_req.dstencil;
      cb = tex_req.texel;
      if (isdepth)
         cb = {`FIS_ONE_F, 32'h0, 32'h0, tex_req.rt};
      rsp_d = '0;
      for (int k = 0; k < 4; k++)
         rsp_d.v[k] = fis_swz(cb, tex_req.swz[k]);
      if (!tex_req.complete) begin
         rsp_d.v = tex_req.shadow ? '0
                 : {`FIS_ONE_F, 32'h0, 32'h0, 32'h0};
         rsp_d.scalar = tex_req.shadow;
      end else if (isdepth) begin
         rsp_d.v = {32'h0, 32'h0, 32'h0, rsp_d.v[0]};
         rsp_d.scalar = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tex_rsp_valid <= 1'b0;
         tex_rsp <= '0;
      end else begin
         tex_rsp_valid <= tex_req_valid;
         if (tex_req_valid)
            tex_rsp <= rsp_d;
      end
   end

   default clocking cb_chk @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_apb_wait;
      apb_acc & ~pready ##1 pready;
   endsequence

   chk_apb_answer: assert property ((apb_acc & ~pready) |-> s_apb_wait)
      else $error("apb answer not one cycle late");
   chk_hold_out: assert property (sh_valid & ~sh_ready |=>
      sh_valid && $stable(sh_out))
      else $error("shader output changed before ready");
   chk_route_shd: assert property (accept & ctrl_q.shd |=>
      !ff_valid ##[30:40] sh_valid)
      else $error("shader fragment misrouted or late");
   chk_batch_zero: assert property (prim_ev.batch |=>
      prim_cnt_q == 32'h0000_0000)
      else $error("primitive counter not cleared");
   chk_piece_keep: assert property (!prim_ev.batch &&
      !(prim_ev.prim_end & prim_ev.last) |=> $stable(prim_cnt_q))
      else $error("primitive counter moved on a piece or restart");
   chk_single_mask: assert property (sh_valid && !ps_q &&
      (!ctrl_q.msen || slog2_q == 3'h0) && $stable(ctrl_q) |->
      sh_out.mask[31:1] == '0 && sh_out.sid == 5'h00 &&
      sh_out.spx == `FIS_POS_CTR)
      else $error("single sample inputs wrong");
   chk_sample_onehot: assert property (sh_valid && ps_q |->
      (eff_q == 32'h0) ? sh_out.mask == 32'h0 && sh_out.sid == 5'h00 :
      sh_out.mask == (32'h1 << sh_out.sid) && (eff_q & sh_out.mask) != 0)
      else $error("per-sample mask not current sample");
   chk_sample_step: assert property (sh_valid & sh_ready & ps_q &
      ~nxt[5] |=> sh_valid && sh_out.sid > $past(sh_out.sid))
      else $error("per-sample run did not advance");
   chk_tex_blank: assert property (tex_req_valid &&
      !tex_req.complete |=> tex_rsp_valid &&
      tex_rsp.v[2:0] == '0 && tex_rsp.scalar == $past(tex_req.shadow))
      else $error("incomplete texture result wrong");
   chk_depth_first: assert property (tex_req_valid &&
      tex_req.complete && isdepth |=> tex_rsp.v[3:1] == '0 &&
      tex_rsp.scalar)
      else $error("depth lookup returned extra components");
endmodule : fis_top

/* File: fis_core_model.sv */
// downstream shading core model: takes shader fragments, fast or slow
`timescale 1ns/1ps
module fis_core_model (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic sh_valid,
   input  wire logic slow,
   output logic      sh_ready
);
   logic [1:0] wait_q;
   // slow mode stalls three cycles so the held output is visible
   always_ff @(posedge sys_clk) begin
      if (reset || !sh_valid || sh_ready)
         wait_q <= 2'h0;
      else
         wait_q <= wait_q + 2'h1;
   end
   assign sh_ready = sh_valid && (!slow || wait_q == 2'h3);
endmodule : fis_core_model

/* File: testbench.sv */
// self-checking bench for the fragment input setup block
`timescale 1ns/1ps
`include "fis_cfg.svh"
module testbench;
   import fis_pkg::*;
   logic          sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata;
   logic          frag_valid, frag_ready, sh_valid, sh_ready, slow;
   logic          ff_valid, ff_ready, tex_req_valid, tex_rsp_valid;
   fis_frag_in_t  frag_in, ff_out;
   fis_frag_out_t sh_out;
   fis_prim_ev_t  prim_ev;
   fis_tex_req_t  tex_req;
   fis_tex_rsp_t  tex_rsp;
   int            miscompares, n_tests;

   fis_top fis_top_inst (.sys_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .frag_valid,
      .frag_ready, .frag_in, .sh_valid, .sh_ready, .sh_out, .ff_valid,
      .ff_ready, .ff_out, .prim_ev, .tex_req_valid, .tex_req,
      .tex_rsp_valid, .tex_rsp);
   fis_core_model fis_core_model_inst (.sys_clk, .reset, .sh_valid,
      .slow, .sh_ready);

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] g, input logic [31:0] x,
                      input string m);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk

   // no fixed wait state assumed; the watchdog bounds the wait
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // answer taken at the very edge that ends the access
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic ex);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x, "read data");
      chk({31'h0, e}, {31'h0, ex}, "slave error");
   endtask : rd

   task automatic send(input fis_frag_in_t f);
      @(posedge sys_clk);
      frag_in    <= f;
      frag_valid <= 1'b1;
      do @(negedge sys_clk); while (frag_ready !== 1'b1);
      @(posedge sys_clk);
      frag_valid <= 1'b0;
   endtask : send

   task automatic get_sh(output fis_frag_out_t o);
      fis_frag_out_t v0;
      do @(negedge sys_clk); while (sh_valid !== 1'b1);
      v0 = sh_out;
      while (sh_ready !== 1'b1) @(negedge sys_clk);
      o = sh_out;
      chk({31'h0, o === v0}, 32'h1, "held output");
      chk({31'h0, ff_valid}, 32'h0, "fixed path idle");
      @(posedge sys_clk);
   endtask : get_sh

   task automatic ev(input logic [3:0] e);
      @(posedge sys_clk);
      prim_ev <= e;
      @(posedge sys_clk);
      prim_ev <= 4'h0;
   endtask : ev

   task automatic tex(input fis_tex_req_t q, input logic [31:0] x,
                      input int k, input string m);
      @(posedge sys_clk);
      tex_req       <= q;
      tex_req_valid <= 1'b1;
      @(posedge sys_clk);
      tex_req_valid <= 1'b0;
      @(negedge sys_clk);
      chk({31'h0, tex_rsp_valid}, 32'h1, "texture answer");
      chk(tex_rsp.v[k], x, m);
   endtask : tex

   initial begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      fis_frag_in_t  f;
      fis_frag_out_t o;
      fis_tex_req_t  q;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {frag_valid, tex_req_valid, slow} = '0;
      frag_in = '0;
      tex_req = '0;
      prim_ev = '0;
      ff_ready = 1'b1;
      reset = 1'b1;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      rd(`FIS_REG_CTRL, 32'h0, 1'b0);
      rd(`FIS_REG_SMASK, `FIS_SMASK_RST, 1'b0);
      rd(8'h18, 32'h0, 1'b1);
      wr(`FIS_REG_PRIM, 32'h5);
      rd(`FIS_REG_PRIM, 32'h0, 1'b0);
      f = '0;
      f.x = 24'h000A80;
      f.y = 24'h000380;
      f.z = `FIS_ONE_F;
      f.wc = 32'h0002_0000;
      f.col_fix = 1'b1;
      f.pcol[0] = 32'h0000_00FF;
      f.poly = 1'b1;
      f.area = 32'sd5;
      f.cov = 32'h0000_000B;
      f.kill = 32'h0000_0002;
      f.gs_id = 32'h0000_0055;
      send(f);
      do @(negedge sys_clk); while (ff_valid !== 1'b1);
      chk({31'h0, ff_out === f}, 32'h1, "fixed path");
      @(posedge sys_clk);
      wr(`FIS_REG_CTRL, 32'h1);
      send(f);
      get_sh(o);
      chk(32'(o.px), 32'h0A80, "x half");
      chk(32'(o.py), 32'h0380, "y lower left");
      chk(o.z, `FIS_ONE_F, "z");
      chk(o.w, 32'h0000_8000, "w");
      chk(o.pcol[0], `FIS_ONE_F, "unorm one");
      chk(o.pcol[1], 32'h0, "unorm zero");
      chk({31'h0, o.front}, 32'h1, "front");
      chk(o.mask, 32'h1, "single mask");
      chk({o.spx, o.spy, 3'h0, o.sid, 2'h0, o.scnt}, 32'h8080_0001,
          "single");
      wr(`FIS_REG_HGT, 32'd100);
      wr(`FIS_REG_CTRL, 32'h0F);
      f.col_fix = 1'b0;
      f.pcol[0] = 32'h3F00_0000;
      send(f);
      get_sh(o);
      chk(32'(o.px), 32'h0A00, "x integer");
      chk(32'(o.py), 32'h6000, "y upper left");
      chk(o.pcol[0], 32'h3F00_0000, "float colour");
      chk({31'h0, o.front}, 32'h0, "reversed");
      ev(4'h6);
      ev(4'h8);
      ev(4'h4);
      ev(4'h6);
      ev(4'h6);
      ev(4'h1);
      rd(`FIS_REG_PRIM, 32'h2, 1'b0);
      wr(`FIS_REG_CTRL, 32'h1);
      f.poly = 1'b0;
      f.area = -32'sd5;
      send(f);
      get_sh(o);
      chk(o.prim_id, 32'h2, "counter id");
      chk({31'h0, o.front}, 32'h1, "non polygon");
      wr(`FIS_REG_CTRL, 32'h41);
      slow <= 1'b1;
      send(f);
      get_sh(o);
      chk(o.prim_id, 32'h55, "geometry id");
      ev(4'hE);
      rd(`FIS_REG_PRIM, 32'h0, 1'b0);
      wr(`FIS_REG_SAMP, 32'h2);
      wr(`FIS_REG_CTRL, 32'h31);
      send(f);
      get_sh(o);
      chk({o.spx, o.mask[23:0]}, 32'h2000_0001, "s0");
      chk({26'h0, o.scnt}, 32'h4, "count");
      get_sh(o);
      chk({o.spx, 3'h0, o.sid, o.mask[15:0]}, 32'hE003_0008,
          "s3");
      wr(`FIS_REG_SMASK, 32'hFFFF_FFFE);
      send(f);
      get_sh(o);
      chk({27'h0, o.sid}, 32'h3, "masked id");
      chk(o.mask, 32'h8, "masked bits");
      wr(`FIS_REG_CTRL, 32'h01);
      send(f);
      get_sh(o);
      chk({o.spx, o.spy, 3'h0, o.sid, 2'h0, o.scnt}, 32'h8080_0004,
          "ms off");
      chk(o.mask, 32'h1, "ms off mask");
      rd(`FIS_REG_INV, 32'h8, 1'b0);
      q = '0;
      q.depth = 1'b1;
      q.complete = 1'b1;
      q.rt = 32'h3F00_0000;
      q.texel = {4{32'h1234_5678}};
      q.swz = {3'h3, 3'h2, 3'h1, 3'h0};
      tex(q, 32'h3F00_0000, 0, "depth red");
      q.swz[0] = `FIS_SW_ONE;
      tex(q, `FIS_ONE_F, 0, "depth one");
      q.swz[0] = 3'h1;
      q.dstencil = 1'b1;
      tex(q, 32'h0, 0, "depth green");
      q.swz[0] = 3'h0;
      tex(q, 32'h3F00_0000, 0, "depth stencil");
      q = '0;
      q.texel = {4{32'h1234_5678}};
      q.swz = {3'h3, 3'h2, 3'h1, 3'h0};
      tex(q, `FIS_ONE_F, 3, "incomplete a");
      tex(q, 32'h0, 0, "incomplete r");
      q.shadow = 1'b1;
      q.depth = 1'b1;
      q.rt = 32'h3F00_0000;
      tex(q, 32'h0, 0, "incomplete shadow");
      report_and_stop();
   end
endmodule : testbench
